/* File: src/crf_top.sv */
/*
  CPU register set with flags, interrupt gating and banked general-purpose
  registers, reached over an AXI4-Lite slave. Assumes a single clock, an
  AXI4-Lite master that keeps one write and one read in flight, and an
  interrupt controller on the same clock giving a request and its level.
*/
`timescale 1ns/1ps
`include "crf_defs.svh"
module crf_top #(
  parameter int NUM_BANKS = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  input wire logic [1:0] irq_req_level,
  output logic irq_take_q,
  output crf_pkg::crf_regs_t cpu_regs
);
  import crf_pkg::*;

  localparam int BW = $clog2(NUM_BANKS);
  localparam int RAW = BW + 3;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Only the three bank counts of the product variants are served.
  if (NUM_BANKS != 8 && NUM_BANKS != 16 && NUM_BANKS != 32) begin : g_bad
    $error("NUM_BANKS must be 8, 16 or 32");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge of a 16-bit register with the write strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // Mask and request codes to priority level, 1 highest, 3 lowest.
  function automatic logic [1:0] lvl(input logic [1:0] code);
    return code[1] ? {1'b1, code[0]} : 2'h1;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] pc_q;
  logic [15:0] acc_q;
  logic [15:0] tmp_q;
  logic [15:0] ix_q;
  logic [15:0] ep_q;
  logic [15:0] sp_q;
  logic [7:0] rp_q;
  crf_ccr_t ccr_q;
  crf_op_t op_q;

  // Bus state.
  logic aw_q;
  logic [7:0] awaddr_q;
  logic w_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------------
  // Write channel acceptance
  // ----------------------------------------------------------------------
  // Address and data are caught independently so either may come first;
  // nothing new is taken until the response has been accepted.
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;

  logic aw_hs;
  logic w_hs;
  logic do_wr;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign do_wr = aw_q && w_q && !bvalid_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (aw_hs) begin
      aw_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_hs) begin
      w_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic wr_pc;
  logic wr_acc;
  logic wr_tmp;
  logic wr_ix;
  logic wr_ep;
  logic wr_sp;
  logic wr_ps;
  logic wr_op;
  logic wr_irq;
  logic wr_gpr;
  logic wr_hit;
  logic op_go;
  logic [15:0] wd16;
  logic [1:0] ws2;

  assign wd16 = wdata_q[15:0];
  assign ws2 = wstrb_q[1:0];
  assign wr_pc = do_wr && awaddr_q == `CRF_OFF_PC;
  assign wr_acc = do_wr && awaddr_q == `CRF_OFF_ACC;
  assign wr_tmp = do_wr && awaddr_q == `CRF_OFF_TMP;
  assign wr_ix = do_wr && awaddr_q == `CRF_OFF_IX;
  assign wr_ep = do_wr && awaddr_q == `CRF_OFF_EP;
  assign wr_sp = do_wr && awaddr_q == `CRF_OFF_SP;
  assign wr_ps = do_wr && awaddr_q == `CRF_OFF_PS;
  assign wr_op = do_wr && awaddr_q == `CRF_OFF_OP;
  assign wr_irq = do_wr && awaddr_q == `CRF_OFF_IRQ;
  assign wr_gpr = do_wr && awaddr_q[7:5] == `CRF_GPR_TAG && awaddr_q[1:0] == 2'h0;
  // The status register is read-only; a write to it is answered OKAY.
  assign wr_hit = wr_pc || wr_acc || wr_tmp || wr_ix || wr_ep || wr_sp ||
                  wr_ps || wr_op || wr_irq || wr_gpr;
  assign op_go = wr_op && wstrb_q[0];

  // Write response is raised on the edge that performs the write.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CRF_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------------
  logic [15:0] alu_res;
  crf_ccr_t alu_ccr;

  crf_alu_flags u_alu (
    .acc(acc_q),
    .tmp(tmp_q),
    .op(crf_op_t'(wdata_q[2:0])),
    .ccr_in(ccr_q),
    .res(alu_res),
    .ccr_out(alu_ccr)
  );

  // ----------------------------------------------------------------------
  // Dedicated 16-bit registers
  // ----------------------------------------------------------------------
  // Program counter, index, extra pointer and stack pointer are plain
  // storage here; the core consumes them through cpu_regs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `CRF_RST_REG;
      ix_q <= `CRF_RST_REG;
      ep_q <= `CRF_RST_REG;
      sp_q <= `CRF_RST_REG;
    end else begin
      pc_q <= wr_pc ? merge16(pc_q, wd16, ws2) : pc_q;
      ix_q <= wr_ix ? merge16(ix_q, wd16, ws2) : ix_q;
      ep_q <= wr_ep ? merge16(ep_q, wd16, ws2) : ep_q;
      sp_q <= wr_sp ? merge16(sp_q, wd16, ws2) : sp_q;
    end
  end

  // Accumulator takes either a bus write or the result of a command.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= `CRF_RST_REG;
      tmp_q <= `CRF_RST_REG;
      op_q <= CRF_OP_ADD;
    end else begin
      acc_q <= op_go ? alu_res : (wr_acc ? merge16(acc_q, wd16, ws2) : acc_q);
      tmp_q <= wr_tmp ? merge16(tmp_q, wd16, ws2) : tmp_q;
      op_q <= op_go ? crf_op_t'(wdata_q[2:0]) : op_q;
    end
  end

  // ----------------------------------------------------------------------
  // Program status word
  // ----------------------------------------------------------------------
  // Upper lane is the bank pointer, lower lane the flag byte. A command
  // and a status write never meet since only one write is in flight.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rp_q <= `CRF_RST_RP;
      ccr_q <= `CRF_RST_CCR;
    end else begin
      if (wr_ps && ws2[1]) begin
        rp_q <= wd16[15:8];
      end
      if (op_go) begin
        ccr_q <= alu_ccr;
      end else if (wr_ps && ws2[0]) begin
        ccr_q <= wd16[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------------
  // A request is taken only with the enable set and a level strictly
  // above the mask level; mask level 1 therefore blocks everything.
  logic [1:0] mask_lvl;
  logic [1:0] req_lvl;
  logic irq_ok;
  assign mask_lvl = lvl(ccr_q.il);
  assign req_lvl = lvl(irq_req_level);
  assign irq_ok = irq_req && ccr_q.i && (req_lvl < mask_lvl);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= irq_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Banked general-purpose registers
  // ----------------------------------------------------------------------
  // Entry index is the low bank pointer bits followed by the register
  // number; pointer bits above the bank count are ignored.
  logic [RAW-1:0] gpr_widx;
  logic [RAW-1:0] gpr_ridx;
  logic [7:0] gpr_rdata;
  assign gpr_widx = {rp_q[BW-1:0], awaddr_q[`CRF_GPR_NUM_LSB +: 3]};
  assign gpr_ridx = {rp_q[BW-1:0], s_axi_araddr[`CRF_GPR_NUM_LSB +: 3]};

  crf_bank_ram #(
    .DEPTH(NUM_BANKS * 8),
    .AW(RAW)
  ) u_ram (
    .clock(clock),
    .we(wr_gpr && wstrb_q[0]),
    .waddr(gpr_widx),
    .wdata(wdata_q[7:0]),
    .raddr(gpr_ridx),
    .rdata(gpr_rdata)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic ar_hs;
  logic [7:0] ra;
  logic rd_gpr;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [31:0] irq_stat;

  assign s_axi_arready = !rvalid_q;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ra = s_axi_araddr;
  assign rd_gpr = ra[7:5] == `CRF_GPR_TAG && ra[1:0] == 2'h0;
  assign irq_stat = ({30'h00000000, mask_lvl} << `CRF_IRQ_LVL_LSB) |
                    ({31'h00000000, irq_req} << `CRF_IRQ_REQ_BIT) |
                    ({31'h00000000, irq_take_q} << `CRF_IRQ_TAKE_BIT);
  assign rd_val = (ra == `CRF_OFF_PC) ? {16'h0000, pc_q} :
                  (ra == `CRF_OFF_ACC) ? {16'h0000, acc_q} :
                  (ra == `CRF_OFF_TMP) ? {16'h0000, tmp_q} :
                  (ra == `CRF_OFF_IX) ? {16'h0000, ix_q} :
                  (ra == `CRF_OFF_EP) ? {16'h0000, ep_q} :
                  (ra == `CRF_OFF_SP) ? {16'h0000, sp_q} :
                  (ra == `CRF_OFF_PS) ? {16'h0000, rp_q, ccr_q} :
                  (ra == `CRF_OFF_OP) ? {29'h00000000, op_q} :
                  (ra == `CRF_OFF_IRQ) ? irq_stat :
                  rd_gpr ? {24'h000000, gpr_rdata} : 32'h00000000;
  assign rd_hit = rd_gpr || ra == `CRF_OFF_PC || ra == `CRF_OFF_ACC ||
                  ra == `CRF_OFF_TMP || ra == `CRF_OFF_IX ||
                  ra == `CRF_OFF_EP || ra == `CRF_OFF_SP ||
                  ra == `CRF_OFF_PS || ra == `CRF_OFF_OP ||
                  ra == `CRF_OFF_IRQ;

  // Data is captured at the address handshake, on the same edge that raises rvalid.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `CRF_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------------
  // Core view
  // ----------------------------------------------------------------------
  assign cpu_regs = '{pc: pc_q, acc: acc_q, tmp: tmp_q, ix: ix_q, ep: ep_q,
                      sp: sp_q, rp: rp_q, condition_flags_byte: ccr_q};

endmodule // crf_top

/* File: src/crf_defs.svh */
/*
  Constants of the CPU register set: bus offsets, field positions, reset
  values and bus answer codes. Assumes inclusion by bare name from a file
  that compiles after it; it holds definitions only.
*/
// Behaviour
// - 16-bit program counter holds fetch location.
// - 16-bit accumulator; 8-bit ops use low byte.
// - 16-bit temporary accumulator, second operand.
// - 16-bit index register modifies addresses.
// - 16-bit extra pointer holds any address.
// - 16-bit stack pointer addresses the stack.
// - Status word: high byte bank, low flags.
// - Banks of eight 8-bit registers, pointer-selected.
// - Bank count is 8, 16 or 32.
// - Half-carry flags carry/borrow bit 3 to 4.
// - Interrupt enable gates interrupts; reset clears it.
// - Serve only requests above mask level.
// - Mask codes 00/01 level1, 10 level2, 11 level3.
// - Negative flag copies result's top bit.
// - Zero flag set on zero result.
// - Overflow flag on two's-complement overflow.
// - Carry from bit 7; shifts load shifted-out bit.
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CRF_OFF_PC 8'h00
`define CRF_OFF_ACC 8'h04
`define CRF_OFF_TMP 8'h08
`define CRF_OFF_IX 8'h0C
`define CRF_OFF_EP 8'h10
`define CRF_OFF_SP 8'h14
`define CRF_OFF_PS 8'h18
`define CRF_OFF_OP 8'h1C
`define CRF_OFF_IRQ 8'h20
`define CRF_GPR_TAG 3'h2
`define CRF_GPR_NUM_LSB 2

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CRF_IRQ_TAKE_BIT 0
`define CRF_IRQ_REQ_BIT 1
`define CRF_IRQ_LVL_LSB 2
`define CRF_RST_REG 16'h0000
`define CRF_RST_RP 8'h00
`define CRF_RST_CCR 8'h00

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define CRF_RESP_OKAY 2'h0
`define CRF_RESP_SLVERR 2'h2

`endif

/* File: src/crf_pkg.sv */
/*
  Types of the CPU register set: flag byte layout, arithmetic commands and
  the bundle of registers offered to the core. Assumes nothing beyond a
  SystemVerilog compiler.
*/
package crf_pkg;

  // Flag byte, most significant field first.
  typedef struct packed {
    logic h;
    logic i;
    logic [1:0] il;
    logic n;
    logic z;
    logic v;
    logic c;
  } crf_ccr_t;

  // Commands written to the operation register.
  typedef enum logic [2:0] {
    CRF_OP_ADD,
    CRF_OP_ADDC,
    CRF_OP_SUB,
    CRF_OP_SUBC,
    CRF_OP_ROLC,
    CRF_OP_RORC,
    CRF_OP_ADDW,
    CRF_OP_SUBW
  } crf_op_t;

  // Register set as the core sees it.
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [7:0] rp;
    crf_ccr_t condition_flags_byte;
  } crf_regs_t;

endpackage

/* File: src/crf_alu_flags.sv */
/*
  Arithmetic and shift unit with flag generation for the accumulator.
  Assumes operands and the old flag byte come from registers on the same
  clock; purely combinational.
*/
`timescale 1ns/1ps
module crf_alu_flags (
  input wire logic [15:0] acc,
  input wire logic [15:0] tmp,
  input wire crf_pkg::crf_op_t op,
  input wire crf_pkg::crf_ccr_t ccr_in,
  output logic [15:0] res,
  output crf_pkg::crf_ccr_t ccr_out
);
  import crf_pkg::*;

  logic [8:0] s8;
  logic [16:0] s16;
  logic cy;
  logic wide;

  // ----------------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------------
  // Byte operations leave the upper accumulator byte untouched.
  always_comb begin
    res = acc;
    ccr_out = ccr_in;
    s8 = 9'h000;
    s16 = 17'h00000;
    cy = (op == CRF_OP_ADDC || op == CRF_OP_SUBC) && ccr_in.c;
    wide = (op == CRF_OP_ADDW || op == CRF_OP_SUBW);
    case (op)
      CRF_OP_ADD, CRF_OP_ADDC: begin
        s8 = {1'b0, acc[7:0]} + {1'b0, tmp[7:0]} + {8'h00, cy};
        res[7:0] = s8[7:0];
        ccr_out.h = acc[4] ^ tmp[4] ^ s8[4];
        ccr_out.c = s8[8];
        ccr_out.v = (acc[7] == tmp[7]) && (s8[7] != acc[7]);
      end
      CRF_OP_SUB, CRF_OP_SUBC: begin
        s8 = {1'b0, acc[7:0]} - {1'b0, tmp[7:0]} - {8'h00, cy};
        res[7:0] = s8[7:0];
        ccr_out.h = acc[4] ^ tmp[4] ^ s8[4];
        ccr_out.c = s8[8];
        ccr_out.v = (acc[7] != tmp[7]) && (s8[7] != acc[7]);
      end
      CRF_OP_ROLC: begin
        res[7:0] = {acc[6:0], ccr_in.c};
        ccr_out.c = acc[7];
      end
      CRF_OP_RORC: begin
        res[7:0] = {ccr_in.c, acc[7:1]};
        ccr_out.c = acc[0];
      end
      CRF_OP_ADDW: begin
        s16 = {1'b0, acc} + {1'b0, tmp};
        res = s16[15:0];
        ccr_out.c = s16[16];
        ccr_out.v = (acc[15] == tmp[15]) && (s16[15] != acc[15]);
      end
      CRF_OP_SUBW: begin
        s16 = {1'b0, acc} - {1'b0, tmp};
        res = s16[15:0];
        ccr_out.c = s16[16];
        ccr_out.v = (acc[15] != tmp[15]) && (s16[15] != acc[15]);
      end
      default: begin
        res = acc;
      end
    endcase
    ccr_out.n = wide ? res[15] : res[7];
    ccr_out.z = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
  end

endmodule // crf_alu_flags

/* File: src/crf_bank_ram.sv */
/*
  Storage for the banked general-purpose registers, one byte per entry.
  Assumes one writer and one reader on the same clock; read is immediate.
*/
`timescale 1ns/1ps
module crf_bank_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // Write and read ports
  // ----------------------------------------------------------------------
  // No reset: register contents are undefined until software writes them.
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule // crf_bank_ram

/* File: tb/crf_top_monitor.sv */
/*
  Checker for the CPU register set: bus handshakes and interrupt gating.
  Assumes only the ports of crf_top; it is bound in at the foot.
*/
`timescale 1ns/1ps
module crf_top_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  input wire logic [1:0] irq_req_level,
  input wire logic irq_take_q,
  input wire crf_pkg::crf_regs_t cpu_regs
);
  import crf_pkg::*;

  // --------
  // Helpers
  // --------
  // Codes 00 and 01 both mean the top level, so plain compare of codes fails.
  function automatic logic [1:0] lvl(input logic [1:0] c);
    return c[1] ? c : 2'h1;
  endfunction
  wire take_c = irq_req && cpu_regs.condition_flags_byte.i && (lvl(irq_req_level) < lvl(cpu_regs.condition_flags_byte.il));

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // --------
  // Properties
  // --------
  // Answers stand until taken, and a busy channel refuses new work.
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  AST_IRQ_OFF: assert property (!cpu_regs.condition_flags_byte.i |=> !irq_take_q)
    else $error("interrupt taken while disabled");
  AST_IRQ_LVL: assert property (1'h1 |=> irq_take_q == $past(take_c))
    else $error("interrupt take disagrees with level mask");

  COV_TAKE: cover property (irq_take_q);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // crf_top_monitor

bind crf_top crf_top_monitor u_mon (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_req_level,
  .irq_take_q, .cpu_regs);

/* File: tb/crf_top_tb.sv */
/*
  Self-checking bench for the CPU register set over AXI4-Lite.
  Assumes crf_top built with eight banks and the monitor bound in.
*/
`timescale 1ns/1ps
module crf_top_tb;
  import crf_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, irq_req = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_take_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, irq_req_level = 2'h0;
  crf_regs_t cpu_regs;
  int mismatches = 0;
  int n_checks = 0;
  // Fields: acc, tmp, flags in, command, acc out, flags out.
  logic [71:0] alu_tbl [12] = '{72'hAB0F_CD01_00_00_AB10_80, 72'h0080_0080_00_00_0000_07,
    72'h007F_0001_00_00_0080_8A, 72'h0010_0001_00_02_000F_80, 72'h0000_0001_00_02_00FF_89,
    72'h0080_0001_00_02_007F_82, 72'h0001_0001_01_01_0003_00, 72'h0005_0001_01_03_0003_00,
    72'h0081_0000_00_04_0002_01, 72'h0001_0000_01_05_0080_09, 72'h8000_8000_00_06_0000_07,
    72'h0000_0001_00_07_FFFF_09};

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  crf_top #(.NUM_BANKS(8)) u_dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_req_level, .irq_take_q,
    .cpu_regs);

  // --------
  // Shared tasks
  // --------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A stuck handshake ends the run rather than hanging it.
  task automatic hang();
    mismatches++;
    $display("ERROR handshake expected answer seen timeout");
    stop_test();
  endtask

  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
  endtask

  // Handshakes are judged 1 ns after each edge, so no race with the edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int k = 0; k < 50; k++) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) begin
        s_axi_bready <= 1'h0;
        @(posedge clock);
        return;
      end
    end
    hang();
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int k = 0; k < 50; k++) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_rready <= 1'h0;
        @(posedge clock);
        return;
      end
    end
    hang();
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdr(8'(i * 4));
      chk("reset value", 32'h0, rdat);
    end
  endtask

  // All words written before any is read, so aliasing shows up.
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      wr(8'(i * 4), 16'(16'h1100 * (i + 1)), 4'h3);
      wr(8'(i * 4), 16'h0077, 4'h1);
    end
    for (int i = 0; i < 6; i++) begin
      rdr(8'(i * 4));
      chk("reg word", 32'(16'h1100 * (i + 1) + 16'h0077), rdat);
    end
    chk("pc out", 32'h1177, 32'(cpu_regs.pc));
    chk("sp out", 32'h6677, 32'(cpu_regs.sp));
    wr(8'h18, 16'h1234, 4'h3);
    chk("bank ptr", 32'h12, 32'(cpu_regs.rp));
    chk("flag byte", 32'h34, 32'(cpu_regs.condition_flags_byte));
  endtask

  task automatic t_alu();
    foreach (alu_tbl[j]) begin
      wr(8'h04, alu_tbl[j][71:56], 4'h3);
      wr(8'h08, alu_tbl[j][55:40], 4'h3);
      wr(8'h18, {8'h00, alu_tbl[j][39:32]}, 4'h3);
      wr(8'h1C, {8'h00, alu_tbl[j][31:24]}, 4'h1);
      chk("acc", 32'(alu_tbl[j][23:8]), 32'(cpu_regs.acc));
      chk("flags", 32'(alu_tbl[j][7:0]), 32'(cpu_regs.condition_flags_byte));
    end
    // A command without the low strobe must leave everything as it was.
    wr(8'h1C, 16'h0000, 4'h2);
    chk("no-strobe acc", 32'hFFFF, 32'(cpu_regs.acc));
    rdr(8'h1C);
    chk("last command", 32'h7, rdat);
  endtask

  // Eight banks: pointer 9 must land on bank 1 again.
  task automatic t_bank();
    wr(8'h18, 16'h0100, 4'h3);
    wr(8'h40, 16'h0011, 4'h1);
    wr(8'h5C, 16'h0017, 4'h1);
    wr(8'h18, 16'h0200, 4'h3);
    wr(8'h40, 16'h0022, 4'h1);
    wr(8'h18, 16'h0900, 4'h3);
    rdr(8'h40);
    chk("bank reg0", 32'h11, rdat);
    rdr(8'h5C);
    chk("bank reg7", 32'h17, rdat);
    wr(8'h18, 16'h0200, 4'h3);
    rdr(8'h40);
    chk("bank two", 32'h22, rdat);
  endtask

  task automatic t_err();
    rdr(8'h60);
    chk("unmapped rresp", 32'h2, 32'(rs));
    chk("unmapped rdata", 32'h0, rdat);
    wr(8'h02, 16'h00FF, 4'h3);
    chk("misaligned bresp", 32'h2, 32'(rs));
    wr(8'h20, 16'h00FF, 4'h3);
    chk("status bresp", 32'h0, 32'(rs));
  endtask

  // Every mask code against every request code, with interrupts enabled.
  task automatic t_irq();
    logic [1:0] lm, lr;
    irq_req <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, 16'(16'h0040 | (m << 4)), 4'h3);
      lm = m[1] ? 2'(m) : 2'h1;
      rdr(8'h20);
      chk("mask level", 32'(lm), 32'(rdat[3:2]));
      chk("request seen", 32'h1, 32'(rdat[1]));
      for (int r = 0; r < 4; r++) begin
        irq_req_level <= 2'(r);
        lr = r[1] ? 2'(r) : 2'h1;
        repeat (2) @(posedge clock);
        #1;
        chk("take", 32'(lr < lm), 32'(irq_take_q));
        @(posedge clock);
      end
    end
    wr(8'h18, 16'h0030, 4'h3);
    irq_req_level <= 2'h0;
    repeat (2) @(posedge clock);
    #1;
    chk("take disabled", 32'h0, 32'(irq_take_q));
    @(posedge clock);
    wr(8'h18, 16'h0040, 4'h3);
    do_reset();
    chk("enable after reset", 32'h0, 32'(cpu_regs.condition_flags_byte.i));
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_alu();
    t_bank();
    t_err();
    t_irq();
    stop_test();
  end
endmodule // crf_top_tb
